//--- dv/serial_async_port_ir_tb_top.sv
// Purpose: Self-checking bench for the serial port with infrared pulse path.
// Assumes: Divisor 2 gives 32 clocks per bit; bready and rready stay high.
// Notes: Register cases run from a table; serial cases follow by hand.
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module serial_async_port_ir_tb_top;
  import sap_pkg::*;
  typedef struct {bit w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_s;
  logic aclk = 1'b0, aresetn = 1'b0, cpu_wait = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata;
  logic rxd, txd_in, txd_out, txd_oe, irq, lo;
  logic [7:0] rv;
  int fails = 0;
  int num_checks = 0;
  int w, g;
  int pw[4] = '{12, 4, 2, 16};
  row_s t[14] = '{
    '{0, ADDR_BAUD_LOWER, 8'h00, LOWER_RESET, RESP_OKAY},
    '{0, ADDR_BAUD_UPPER, 8'h00, UPPER_RESET, RESP_OKAY},
    '{0, ADDR_CTRL_ONE, 8'h00, CTRL_RESET, RESP_OKAY},
    '{0, 8'h3C, 8'h00, 8'h00, RESP_SLVERR},
    '{1, ADDR_STATUS, 8'h0F, 8'h00, RESP_SLVERR},
    '{0, ADDR_IRQ_CLEAR, 8'h00, 8'h00, RESP_SLVERR},
    '{1, ADDR_CTRL_ONE, 8'h43, 8'h00, RESP_OKAY},
    '{0, ADDR_CTRL_ONE, 8'h00, 8'h43, RESP_OKAY},
    '{1, ADDR_MISC, 8'h01, 8'h00, RESP_OKAY},
    '{0, ADDR_CTRL_ONE, 8'h00, 8'h00, RESP_SLVERR},
    '{1, ADDR_CTRL_ONE, 8'h00, 8'h00, RESP_SLVERR},
    '{1, ADDR_MISC, 8'h00, 8'h00, RESP_OKAY},
    '{0, ADDR_CTRL_ONE, 8'h00, 8'h43, RESP_OKAY},
    '{1, ADDR_CTRL_ONE, 8'h00, 8'h00, RESP_OKAY}};

  always #10 aclk = ~aclk;
  // The single-wire pin carries the port's drive while enabled, else the node's.
  assign txd_in = txd_oe ? txd_out : rxd;

  serial_async_port_ir u_dut (.*);
  serial_node_model #(.BIT_CLKS(32)) u_node (.clk(aclk), .line_in(txd_out), .line_out(rxd));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tmo(input bit hit);
    if (hit)
    begin
      fails++;
      $display("[ERR] wait exp done got timeout");
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    tmo(n >= 99);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    tmo(n >= 99);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Width of the first low run on the pin and the high gap after it, in clocks.
  task automatic low_run();
    int n;
    w = 0;
    g = 0;
    for (n = 0; n < 3000 && txd_out; n++) @(posedge aclk);
    for (; w < 3000 && !txd_out; w++) @(posedge aclk);
    for (; g < 3000 && txd_out; g++) @(posedge aclk);
    tmo(n >= 3000);
  endtask
  task automatic txm(input logic [7:0] b);
    fork
      low_run();
      wr(ADDR_DATA, b, rs);
    join
  endtask
  task automatic still(input int n);
    lo = 1'b0;
    repeat (n)
    begin
      @(posedge aclk);
      lo = lo | !txd_out;
    end
  endtask

  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    foreach (t[i])
    begin
      if (t[i].w) wr(t[i].a, t[i].d, rs);
      else rd(t[i].a, rv, rs);
      if (!t[i].w) `CHK("rdata", t[i].e, rv)
      `CHK("resp", t[i].r, rs)
    end
    wr(ADDR_BAUD_LOWER, 8'h00, rs);
    wr(ADDR_CTRL_TWO, 8'h08, rs);
    wr(ADDR_DATA, 8'h55, rs);
    still(300);
    `CHK("div zero idle", 1'b0, lo)
    fork
      low_run();
      u_node.recv(rv);
      wr(ADDR_BAUD_LOWER, 8'h02, rs);
    join
    `CHK("bit width", 32, w)
    `CHK("bit gap", 32, g)
    `CHK("tx byte", 8'h55, rv)
    cyc(64);
    wr(ADDR_BAUD_UPPER, 8'h01, rs);
    txm(8'h55);
    `CHK("staged upper", 32, w)
    cyc(320);
    wr(ADDR_BAUD_UPPER, 8'h00, rs);
    cpu_wait <= 1'b1;
    txm(8'h55);
    `CHK("wait running", 32, w)
    cyc(320);
    wr(ADDR_CTRL_ONE, 8'h40, rs);
    wr(ADDR_DATA, 8'h55, rs);
    still(300);
    `CHK("wait stopped", 1'b0, lo)
    rd(ADDR_CTRL_TWO, rv, rs);
    `CHK("enables kept", 8'h08, rv)
    fork
      low_run();
      cpu_wait <= 1'b0;
    join
    `CHK("resumed", 32, w)
    cyc(320);
    wr(ADDR_CTRL_ONE, 8'h00, rs);
    wr(ADDR_CTRL_TWO, 8'h0C, rs);
    wr(ADDR_CTRL_ONE, 8'h80, rs);
    fork
      u_node.send(8'h3C, 1'b0, 1'b0);
      wr(ADDR_DATA, 8'hA5, rs);
    join
    cyc(100);
    rd(ADDR_DATA, rv, rs);
    `CHK("loop data", 8'hA5, rv)
    wr(ADDR_CTRL_ONE, 8'h82, rs);
    wr(ADDR_DATA, 8'h5A, rs);
    cyc(400);
    rd(ADDR_DATA, rv, rs);
    `CHK("polarity clash", 1'b0, rv === 8'h5A)
    wr(ADDR_CTRL_ONE, 8'h00, rs);
    cyc(400);
    wr(ADDR_IRQ_CLEAR, 8'h0F, rs);
    u_node.send(8'hC3, 1'b1, 1'b0);
    cyc(20);
    rd(ADDR_DATA, rv, rs);
    `CHK("noisy byte", 8'hC3, rv)
    rd(ADDR_STATUS, rv, rs);
    `CHK("noise flag", 1'b1, rv[ST_NOISE])
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_ENABLE, 8'h04, rs);
    cyc(1);
    `CHK("irq raised", 1'b1, irq)
    wr(ADDR_IRQ_CLEAR, 8'h04, rs);
    cyc(1);
    `CHK("irq cleared", 1'b0, irq)
    wr(ADDR_CTRL_TWO, 8'h04, rs);
    wr(ADDR_CTRL_ONE, 8'hA2, rs);
    u_node.idle(1'b0);
    cyc(100);
    u_node.send(8'h96, 1'b0, 1'b1);
    cyc(20);
    rd(ADDR_DATA, rv, rs);
    `CHK("single wire", 8'h96, rv)
    wr(ADDR_CTRL_ONE, 8'h00, rs);
    u_node.idle(1'b1);
    wr(ADDR_CTRL_TWO, 8'h08, rs);
    // Divisor 5 in infrared mode must act as 4, giving 64 clocks a bit.
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_BAUD_UPPER, {1'b1, 2'(s), 5'h00}, rs);
      wr(ADDR_BAUD_LOWER, 8'h05, rs);
      txm(8'h55);
      `CHK("pulse width", pw[s], w)
      `CHK("infrared gap", 128 - pw[s], g)
      cyc(700);
    end
    wr(ADDR_BAUD_UPPER, 8'h00, rs);
    wr(ADDR_BAUD_LOWER, 8'h02, rs);
    txm(8'h55);
    `CHK("infrared off", 32, w)
    cyc(320);
    finish_test();
  end
endmodule

//--- dv/serial_node_model.sv
// Purpose: Remote serial node that sends and samples 8N1 frames for the port.
// Assumes: A bit time is a whole number of bus clocks.
// Notes: Drives its line only just after clock edges; the bench sets the idle level.
`timescale 1ns/1ns
module serial_node_model #(
  parameter int BIT_CLKS = 32
)(
  input wire logic clk, // Shared bus clock.
  input wire logic line_in, // Line driven by the port.
  output logic line_out // Line towards the port.
);
  initial line_out = 1'b1;
  task automatic idle(input logic l);
    line_out <= l;
  endtask
  // The glitch sits early in the start bit, well clear of the centre vote.
  task automatic send(input logic [7:0] b, input logic gl, input logic inv);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10 * BIT_CLKS; i++)
    begin
      line_out <= f[i / BIT_CLKS] ^ inv ^ (gl && i >= 6 && i < 10);
      @(posedge clk);
    end
    line_out <= ~inv;
  endtask
  task automatic recv(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 4000 && line_in; i++) @(posedge clk);
    repeat (BIT_CLKS * 3 / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = line_in;
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
endmodule

//--- src/sap_pkg.sv
// Purpose: Constants for the asynchronous serial port with infrared pulse path.
// Assumes: AXI4-Lite register access, one aligned 32-bit word per register.
// Notes: Notes on behaviour follow.
package sap_pkg;
  localparam logic [7:0] ADDR_BAUD_UPPER = 8'h00;
  localparam logic [7:0] ADDR_BAUD_LOWER = 8'h04;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h08;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] ADDR_MISC = 8'h20;
  localparam int BIT_INFRARED_ENABLE = 7;
  localparam int BIT_INTERNAL_LOOPBACK = 7;
  localparam int BIT_SWAI = 6;
  localparam int BIT_RX_SOURCE_SELECT = 5;
  localparam int BIT_TX_ENABLE = 3;
  localparam int BIT_RX_ENABLE = 2;
  localparam int BIT_RXPOLI = 1;
  localparam int BIT_TXPOLI = 0;
  localparam int BIT_ALT_MAP_SELECT = 0;
  localparam int ST_TX_DONE = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAME = 3;
  localparam logic [7:0] UPPER_RESET = 8'h00;
  localparam logic [7:0] LOWER_RESET = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] PW_QUARTER = 5'h08;
  localparam logic [4:0] PW_32ND = 5'h01;
  localparam logic [4:0] PW_16TH = 5'h02;
  localparam logic [4:0] PW_3_16 = 5'h06;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11,
    TX_STOP = 2'b10} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
    RX_STOP = 2'b10} rx_state_e;
endpackage

//--- src/serial_async_port_ir.sv
// Purpose: Asynchronous serial port with baud generator, infrared pulse path and loopback.
// Assumes: Single clock aclk, synchronous active-low reset, AXI4-Lite slave.
// Notes: Eight data bits, one stop bit, no parity; rx pin is synchronised first.
`timescale 1ns/1ns
module serial_async_port_ir
  import sap_pkg::*;
(
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic cpu_wait, // Processor is in wait mode.
  input wire logic rxd, // Receive pin.
  input wire logic txd_in, // Transmit pin level, read back in single-wire mode.
  output logic txd_out, // Transmit pin drive.
  output logic txd_oe, // Transmit pin drive enable.
  output logic irq // Level interrupt.
);
  logic [7:0] upper_reg, upper_stage_reg, lower_reg, ctrl_reg, ctrl2_reg, misc_reg;
  logic [3:0] irq_en_reg, status_reg;
  logic started_reg;
  logic [12:0] div_cnt_reg;
  logic tick;
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [7:0] tx_hold_reg, rx_data_reg;
  logic tx_pend_reg;
  logic [12:0] divisor;
  logic infrared_enable, gen_run, clk_stop;
  logic rx_s1_reg, rx_s2_reg, txp_s1_reg, txp_s2_reg;
  logic wr_fire, rd_fire;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;
  logic tx_set_done, rx_set_full, rx_set_noise, rx_set_frame;

  function automatic logic [4:0] pulse_width(input logic [1:0] sel);
    case (sel)
      2'b11: pulse_width = PW_QUARTER;
      2'b10: pulse_width = PW_32ND;
      2'b01: pulse_width = PW_16TH;
      default: pulse_width = PW_3_16;
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a, input logic alternate_map_select);
    case (a)
      ADDR_BAUD_UPPER, ADDR_BAUD_LOWER, ADDR_CTRL_TWO, ADDR_DATA, ADDR_STATUS,
      ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR, ADDR_MISC: addr_mapped = 1'b1;
      ADDR_CTRL_ONE: addr_mapped = ~alternate_map_select;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  assign infrared_enable = upper_reg[BIT_INFRARED_ENABLE];
  assign divisor = {upper_reg[4:0], lower_reg};
  assign clk_stop = ctrl_reg[BIT_SWAI] & cpu_wait;
  // The generator runs at sixteen ticks per bit; infrared drops divisor bit 0, so bits 12:1 count each half tick.
  assign gen_run = started_reg & ~clk_stop &
    (infrared_enable ? (divisor[12:1] != 12'h000) : (divisor != 13'h0000));

  // Bus slave: address and data may arrive in either order.
  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_ok = addr_mapped(aw_addr_reg, misc_reg[BIT_ALT_MAP_SELECT]) &
    (aw_addr_reg != ADDR_STATUS);
  assign rd_ok = addr_mapped(s_axi_araddr, misc_reg[BIT_ALT_MAP_SELECT]) &
    (s_axi_araddr != ADDR_IRQ_CLEAR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_byte;
  assign wr_byte = wr_fire & wr_ok & w_strb_reg[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upper_reg <= UPPER_RESET;
      upper_stage_reg <= UPPER_RESET;
      lower_reg <= LOWER_RESET;
      ctrl_reg <= CTRL_RESET;
      ctrl2_reg <= CTRL_RESET;
      misc_reg <= CTRL_RESET;
      irq_en_reg <= 4'h0;
    end
    else if (wr_byte)
    begin
      case (aw_addr_reg)
        ADDR_BAUD_UPPER: upper_stage_reg <= w_data_reg[7:0];
        ADDR_BAUD_LOWER:
        begin
          lower_reg <= w_data_reg[7:0];
          upper_reg <= upper_stage_reg;
        end
        ADDR_CTRL_ONE: ctrl_reg <= w_data_reg[7:0];
        ADDR_CTRL_TWO: ctrl2_reg <= w_data_reg[7:0];
        ADDR_MISC: misc_reg <= {7'h00, w_data_reg[BIT_ALT_MAP_SELECT]};
        ADDR_IRQ_ENABLE: irq_en_reg <= w_data_reg[3:0];
        default: ;
      endcase
    end
  end

  // The generator start latches for good once either enable has been seen; wait stop or a zero divisor still halts ticks.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      started_reg <= 1'b0;
    else if (ctrl2_reg[BIT_TX_ENABLE] || ctrl2_reg[BIT_RX_ENABLE])
      started_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_cnt_reg <= 13'h0001;
    else if (!gen_run)
      div_cnt_reg <= 13'h0001;
    else if (div_cnt_reg >= (infrared_enable ? {divisor[12:1], 1'b0} : divisor))
      div_cnt_reg <= 13'h0001;
    else
      div_cnt_reg <= div_cnt_reg + 13'h0001;
  end
  assign tick = gen_run & (div_cnt_reg >= (infrared_enable ? {divisor[12:1], 1'b0} : divisor));

  // Transmitter.
  tx_state_e tx_state_reg;
  logic [3:0] tx_ph_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  logic tx_level, tx_line, tx_pulse;
  logic tx_go;
  assign tx_go = wr_byte & (aw_addr_reg == ADDR_DATA);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_reg <= TX_IDLE;
      tx_ph_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
      tx_hold_reg <= 8'h00;
    end
    else
    begin
      if (tx_go)
      begin
        tx_hold_reg <= w_data_reg[7:0];
        tx_pend_reg <= 1'b1;
      end
      if (tick)
      begin
        tx_ph_reg <= tx_ph_reg + 4'h1;
        case (tx_state_reg)
          TX_IDLE:
            if (tx_pend_reg && ctrl2_reg[BIT_TX_ENABLE])
            begin
              tx_state_reg <= TX_START;
              tx_sh_reg <= tx_hold_reg;
              tx_pend_reg <= tx_go;
              tx_ph_reg <= 4'h0;
            end
          TX_START:
            if (tx_ph_reg == 4'hF)
            begin
              tx_state_reg <= TX_DATA;
              tx_bit_reg <= 3'h0;
            end
          TX_DATA:
            if (tx_ph_reg == 4'hF)
            begin
              tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'h7)
                tx_state_reg <= TX_STOP;
            end
          TX_STOP:
            if (tx_ph_reg == 4'hF)
              tx_state_reg <= TX_IDLE;
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end
  assign tx_set_done = tick & (tx_state_reg == TX_STOP) & (tx_ph_reg == 4'hF);

  always_comb
  begin
    case (tx_state_reg)
      TX_START: tx_level = 1'b0;
      TX_DATA: tx_level = tx_sh_reg[0];
      default: tx_level = 1'b1;
    endcase
  end
  // Infrared sends a narrow pulse for each zero; the width counts in 32nds of a bit.
  // The half-tick flag splits each sixteenth so that the 1/32 width is exact.
  logic tx_half;
  assign tx_half = div_cnt_reg > {1'b0, divisor[12:1]};
  assign tx_pulse = ~tx_level & ({tx_ph_reg, tx_half} < pulse_width(upper_reg[6:5]));
  assign tx_line = (infrared_enable ? ~tx_pulse : tx_level) ^ ctrl_reg[BIT_TXPOLI];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
    end
    else
    begin
      txd_out <= tx_line;
      txd_oe <= ctrl2_reg[BIT_TX_ENABLE];
    end
  end

  // Receiver input routing; pin signals pass two flip-flops first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      txp_s1_reg <= 1'b1;
      txp_s2_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
      txp_s1_reg <= txd_in;
      txp_s2_reg <= txp_s1_reg;
    end
  end

  logic rx_src, rx_bit;
  always_comb
  begin
    if (ctrl_reg[BIT_INTERNAL_LOOPBACK] && !ctrl_reg[BIT_RX_SOURCE_SELECT])
      rx_src = tx_line;
    else if (ctrl_reg[BIT_INTERNAL_LOOPBACK])
      rx_src = txp_s2_reg;
    else
      rx_src = rx_s2_reg;
  end
  // Inversion applies after the route, so mismatched polarities corrupt looped data.
  assign rx_bit = rx_src ^ ctrl_reg[BIT_RXPOLI];

  rx_state_e rx_state_reg;
  logic [3:0] rx_ph_reg;
  logic [2:0] rx_hist_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [1:0] rx_vote_reg;
  logic rx_noise_reg;
  logic rx_sample;
  assign rx_sample = tick & ctrl2_reg[BIT_RX_ENABLE];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_reg <= RX_IDLE;
      rx_ph_reg <= 4'h0;
      rx_hist_reg <= 3'h7;
      rx_cnt_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_vote_reg <= 2'h0;
      rx_noise_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end
    else if (rx_sample)
    begin
      rx_hist_reg <= {rx_hist_reg[1:0], rx_bit};
      rx_ph_reg <= rx_ph_reg + 4'h1;
      if (rx_ph_reg >= 4'h7 && rx_ph_reg <= 4'h9)
        rx_vote_reg <= rx_vote_reg + {1'b0, rx_bit};
      if (rx_ph_reg == 4'h7)
        rx_vote_reg <= {1'b0, rx_bit};
      case (rx_state_reg)
        RX_IDLE:
          if (!rx_bit && rx_hist_reg == 3'b111)
          begin
            rx_state_reg <= RX_START;
            rx_ph_reg <= 4'h1;
            rx_noise_reg <= 1'b0;
          end
        RX_START:
        begin
          // A high sample before phase 7 of the start bit is noise, but the timing is kept.
          if (rx_bit && rx_ph_reg < 4'h7)
            rx_noise_reg <= 1'b1;
          if (rx_ph_reg == 4'hF)
          begin
            if (rx_vote_reg[1])
              rx_state_reg <= RX_IDLE;
            else
              rx_state_reg <= RX_DATA;
            rx_cnt_reg <= 3'h0;
          end
        end
        RX_DATA:
          if (rx_ph_reg == 4'hF)
          begin
            rx_sh_reg <= {rx_vote_reg[1], rx_sh_reg[7:1]};
            if (rx_vote_reg == 2'h1 || rx_vote_reg == 2'h2)
              rx_noise_reg <= 1'b1;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == 3'h7)
              rx_state_reg <= RX_STOP;
          end
        RX_STOP:
          if (rx_ph_reg == 4'hF)
          begin
            rx_data_reg <= rx_sh_reg;
            rx_state_reg <= RX_IDLE;
          end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  logic rx_end;
  assign rx_end = rx_sample & (rx_state_reg == RX_STOP) & (rx_ph_reg == 4'hF);
  assign rx_set_full = rx_end;
  assign rx_set_noise = rx_end & rx_noise_reg;
  assign rx_set_frame = rx_end & ~rx_vote_reg[1];

  // Sticky status: a new event wins over a clear in the same cycle.
  logic [3:0] st_set, st_clr;
  assign st_set = {rx_set_frame, rx_set_noise, rx_set_full, tx_set_done};
  assign st_clr = (wr_byte && aw_addr_reg == ADDR_IRQ_CLEAR) ? w_data_reg[3:0] : 4'h0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= 4'h0;
    else
      status_reg <= (status_reg & ~st_clr) | st_set;
  end
  assign irq = |(status_reg & irq_en_reg);

  always_comb
  begin
    case (s_axi_araddr)
      ADDR_BAUD_UPPER: rd_word = {24'h000000, upper_reg};
      ADDR_BAUD_LOWER: rd_word = {24'h000000, lower_reg};
      ADDR_CTRL_ONE: rd_word = {24'h000000, ctrl_reg};
      ADDR_CTRL_TWO: rd_word = {24'h000000, ctrl2_reg};
      ADDR_DATA: rd_word = {24'h000000, rx_data_reg};
      ADDR_STATUS: rd_word = {28'h0000000, status_reg};
      ADDR_IRQ_ENABLE: rd_word = {28'h0000000, irq_en_reg};
      ADDR_MISC: rd_word = {24'h000000, misc_reg};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_word : 32'h00000000;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  AST_GEN_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
    !started_reg |-> !tick) else $error("Baud tick before any enable.");
  AST_ZERO_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    (!infrared_enable && divisor == 13'h0000) |-> !tick) else $error("Tick with zero divisor.");
  AST_IR_ZERO_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    (infrared_enable && divisor[12:1] == 12'h000) |-> !tick) else $error("Tick with zero ir divisor.");
  AST_WAIT_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_stop |-> !tick) else $error("Tick while stopped in wait.");
  AST_STAGED: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_byte && aw_addr_reg == ADDR_BAUD_UPPER) |=> $stable(upper_reg))
    else $error("Upper baud byte applied early.");
  AST_APPLY: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_byte && aw_addr_reg == ADDR_BAUD_LOWER) |=> upper_reg == $past(upper_stage_reg))
    else $error("Staged byte not applied.");
  AST_LOOP_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[BIT_INTERNAL_LOOPBACK] && !ctrl_reg[BIT_RX_SOURCE_SELECT]) |-> rx_src == tx_line)
    else $error("Loopback not routed.");
  AST_START_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_state_reg == RX_IDLE && rx_sample && rx_hist_reg != 3'b111) |=> rx_state_reg == RX_IDLE)
    else $error("Start taken without three high samples.");
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(status_reg & irq_en_reg)) else $error("Interrupt level wrong.");
  AST_TE_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_stop && !wr_byte) |=> $stable(ctrl2_reg)) else $error("Enables changed in wait.");
endmodule
